/* tcaux_defines.svh */
`ifndef TCAUX_DEFINES_SVH
`define TCAUX_DEFINES_SVH
// APB register byte offsets
`define TCAUX_SEL_OFF       12'h000
`define TCAUX_FMT_OFF       12'h004
`define TCAUX_AUX_OFF       12'h008
`define TCAUX_CLK_OFF       12'h00c
`define TCAUX_LINE_OFF      12'h010
`define TCAUX_FRAME_OFF     12'h014
`define TCAUX_STAT_OFF      12'h018
// Field positions in the aux register
`define TCAUX_AUX_MAG_LSB   0
`define TCAUX_AUX_SIGN_BIT  5
`define TCAUX_AUX_EN_BIT    6
`define TCAUX_CFSYNC_BIT    7
// Field positions in the format register
`define TCAUX_FMT_UB_LSB    4
// Magnitude in half hours: 24 is 12.0 h
`define TCAUX_AUX_MAG_MAX   5'h18
// Phasing limits; clock offset in ns
`define TCAUX_CLK_MAX_NTSC_NS 17'hf81f
`define TCAUX_CLK_MAX_25_NS   17'hf9db
`define TCAUX_LINE_MAX_NTSC   10'h20c
`define TCAUX_LINE_MAX_25     10'h270
`define TCAUX_FRAME_MAX_NTSC  5'h1d
`define TCAUX_FRAME_MAX_25    5'h18
`define TCAUX_FRAME_MAX_24    5'h17
// Line and frame periods in ns, rounded to whole ns
`define TCAUX_LINE_NS_NTSC    32'h0000_f8ec
`define TCAUX_LINE_NS_25      32'h0000_fa00
`define TCAUX_FRAME_NS_NTSC   32'h01fd_cd65
`define TCAUX_FRAME_NS_30     32'h01fc_a055
`define TCAUX_FRAME_NS_25     32'h0262_5a00
// Clock period in ns, 40 MHz
`define TCAUX_CLK_PERIOD_NS  17'h00019
// Reset values
`define TCAUX_RST_ZERO       32'h0000_0000
`endif

/* tcaux_pkg.sv */
package tcaux_pkg;
   typedef enum logic [2:0] {
      TCAUX_NTSC_NONDROP_STD = 3'b000,
      TCAUX_NTSC_DROP_STD    = 3'b001,
      TCAUX_STD_25FPS        = 3'b010,
      TCAUX_STD_30FPS_NONDROP= 3'b011,
      TCAUX_STD_24FPS_NONDROP= 3'b100
   } tcaux_std_type;

   typedef enum logic [1:0] {
      TCAUX_SEL_LTC_A  = 2'b00,
      TCAUX_SEL_LTC_B  = 2'b01,
      TCAUX_SEL_VITC_A = 2'b10,
      TCAUX_SEL_VITC_B = 2'b11
   } tcaux_out_type;

   typedef enum logic [1:0] {
      TCAUX_UB_PLAIN    = 2'b00,
      TCAUX_UB_EXTENDED = 2'b01,
      TCAUX_UB_JULIAN   = 2'b10,
      TCAUX_UB_MJD      = 2'b11
   } tcaux_ub_type;

   typedef struct packed {
      logic [16:0] clock_ns;
      logic [9:0]  lines;
      logic [4:0]  frames;
   } tcaux_phase_type;

   // Per-output view for the timecode generator
   typedef struct packed {
      tcaux_std_type   output_tc_format;
      tcaux_ub_type    user_bit_format;
      logic            aux_insert;
      logic [5:0]      aux_offset_signed;
      logic            color_frame_sync;
   } tcaux_cfg_type;
endpackage : tcaux_pkg

/* tcaux_ctrl.sv */
// Operation
// - Aux offset only with extended user bits
// - Half-hour steps, range -11.5 to +12.0
// - Offset goes to payload, not time
// - Magnitude 0 to 12.0 h, sign separate
// - Minus twelve is treated as +12.0
// - Enable gates aux offset insertion
// - Phasing only on the two linear outputs
// - Phasing stored per output per standard
// - 24 fps non-drop has no phasing
// - Clock, line, frame offsets form one delay
// - Phasing adds to color-frame alignment
// - NTSC/30 limits 63.519 us, 524, 29
// - 25 fps limits 63.963 us, 624, 24
`timescale 1ns/100ps
`default_nettype none
`include "tcaux_defines.svh"

module tcaux_ctrl
   import tcaux_pkg::*;
#(
   parameter int NUM_OUT = 4,
   parameter int NUM_STD = 5
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [NUM_OUT-1:0]    cf_align_ns_valid,
   input  wire logic [NUM_OUT*17-1:0] cf_align_ns,
   output tcaux_cfg_type [NUM_OUT-1:0] out_cfg,
   output logic [NUM_OUT*32-1:0]       ltc_delay_ns
);

   tcaux_out_type                           sel_q;
   tcaux_std_type [NUM_OUT-1:0]             fmt_q;
   tcaux_ub_type  [NUM_OUT-1:0]             ub_q;
   logic          [NUM_OUT-1:0][4:0]        mag_q;
   logic          [NUM_OUT-1:0]             sign_q;
   logic          [NUM_OUT-1:0]             aen_q;
   logic          [NUM_OUT-1:0]             cfs_q;
   // Phasing store exists for the two linear outputs only
   tcaux_phase_type [1:0][NUM_STD-1:0]      ph_q;
   logic          [31:0]                    prdata_q;
   logic          [NUM_OUT*32-1:0]          delay_q;

   logic wr_en;
   logic rd_en;
   logic sel_ltc;
   logic [0:0] li;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign sel_ltc = (sel_q == TCAUX_SEL_LTC_A) || (sel_q == TCAUX_SEL_LTC_B);
   assign li      = sel_q[0];

   function automatic logic [16:0] clk_max(input tcaux_std_type s);
      case (s)
         TCAUX_STD_25FPS:         clk_max = `TCAUX_CLK_MAX_25_NS;
         TCAUX_STD_24FPS_NONDROP: clk_max = 17'h00000;
         default:                 clk_max = `TCAUX_CLK_MAX_NTSC_NS;
      endcase
   endfunction : clk_max

   function automatic logic [9:0] line_max(input tcaux_std_type s);
      case (s)
         TCAUX_STD_25FPS:         line_max = `TCAUX_LINE_MAX_25;
         TCAUX_STD_24FPS_NONDROP: line_max = 10'h000;
         default:                 line_max = `TCAUX_LINE_MAX_NTSC;
      endcase
   endfunction : line_max

   function automatic logic [4:0] frame_max(input tcaux_std_type s);
      case (s)
         TCAUX_STD_25FPS:         frame_max = `TCAUX_FRAME_MAX_25;
         TCAUX_STD_24FPS_NONDROP: frame_max = `TCAUX_FRAME_MAX_24;
         default:                 frame_max = `TCAUX_FRAME_MAX_NTSC;
      endcase
   endfunction : frame_max

   function automatic logic valid_std(input logic [2:0] v);
      valid_std = (v <= 3'b100);
   endfunction : valid_std

   tcaux_std_type cur_std;
   assign cur_std = fmt_q[sel_q];

   // Selected output steers every per-output write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_q <= TCAUX_SEL_LTC_A;
      end else if (wr_en && paddr == `TCAUX_SEL_OFF) begin
         sel_q <= tcaux_out_type'(pwdata[1:0]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fmt_q <= '0;
         ub_q  <= '0;
      end else if (wr_en && paddr == `TCAUX_FMT_OFF) begin
         // Unknown format codes are ignored so stored phasing stays valid
         if (valid_std(pwdata[2:0])) begin
            fmt_q[sel_q] <= tcaux_std_type'(pwdata[2:0]);
         end
         ub_q[sel_q] <= tcaux_ub_type'(pwdata[`TCAUX_FMT_UB_LSB +: 2]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mag_q  <= '0;
         sign_q <= '0;
         aen_q  <= '0;
         cfs_q  <= '0;
      end else if (wr_en && paddr == `TCAUX_AUX_OFF) begin
         // Over-range magnitude saturates at 12.0 h
         if (pwdata[`TCAUX_AUX_MAG_LSB +: 5] > `TCAUX_AUX_MAG_MAX) begin
            mag_q[sel_q] <= `TCAUX_AUX_MAG_MAX;
         end else begin
            mag_q[sel_q] <= pwdata[`TCAUX_AUX_MAG_LSB +: 5];
         end
         sign_q[sel_q] <= pwdata[`TCAUX_AUX_SIGN_BIT];
         aen_q[sel_q]  <= pwdata[`TCAUX_AUX_EN_BIT];
         cfs_q[sel_q]  <= pwdata[`TCAUX_CFSYNC_BIT];
      end
   end

   // Phasing writes go to the slot of the output's current standard
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ph_q <= '0;
      end else if (wr_en && sel_ltc && cur_std != TCAUX_STD_24FPS_NONDROP) begin
         if (paddr == `TCAUX_CLK_OFF) begin
            if (pwdata[31:17] != 15'h0000 || pwdata[16:0] > clk_max(cur_std)) begin
               ph_q[li][cur_std].clock_ns <= clk_max(cur_std);
            end else begin
               ph_q[li][cur_std].clock_ns <= pwdata[16:0];
            end
         end else if (paddr == `TCAUX_LINE_OFF) begin
            if (pwdata[31:10] != 22'h000000 || pwdata[9:0] > line_max(cur_std)) begin
               ph_q[li][cur_std].lines <= line_max(cur_std);
            end else begin
               ph_q[li][cur_std].lines <= pwdata[9:0];
            end
         end else if (paddr == `TCAUX_FRAME_OFF) begin
            if (pwdata[31:5] != 27'h0000000 || pwdata[4:0] > frame_max(cur_std)) begin
               ph_q[li][cur_std].frames <= frame_max(cur_std);
            end else begin
               ph_q[li][cur_std].frames <= pwdata[4:0];
            end
         end
      end
   end

   // Line period in ns for each standard family
   function automatic logic [31:0] line_ns(input tcaux_std_type s);
      line_ns = (s == TCAUX_STD_25FPS) ? `TCAUX_LINE_NS_25 : `TCAUX_LINE_NS_NTSC;
   endfunction : line_ns

   function automatic logic [31:0] frame_ns(input tcaux_std_type s);
      case (s)
         TCAUX_STD_25FPS: frame_ns = `TCAUX_FRAME_NS_25;
         TCAUX_STD_30FPS_NONDROP: frame_ns = `TCAUX_FRAME_NS_30;
         default: frame_ns = `TCAUX_FRAME_NS_NTSC;
      endcase
   endfunction : frame_ns

   // Delay is registered; multipliers are kept off the bus path
   always_ff @(posedge core_clk) begin
      if (rst) begin
         delay_q <= '0;
      end else begin
         for (int o = 0; o < NUM_OUT; o++) begin
            logic [31:0] sum;
            tcaux_phase_type p;
            sum = 32'h0000_0000;
            p = '0;
            if (o < 2 && fmt_q[o] != TCAUX_STD_24FPS_NONDROP) begin
               p = ph_q[o[0]][fmt_q[o]];
               sum = 32'(p.clock_ns) + 32'(32'(p.lines) * line_ns(fmt_q[o]))
                   + 32'(32'(p.frames) * frame_ns(fmt_q[o]));
            end
            if (cfs_q[o] && cf_align_ns_valid[o]) begin
               sum = sum + 32'(cf_align_ns[o*17 +: 17]);
            end
            delay_q[o*32 +: 32] <= sum;
         end
      end
   end
   assign ltc_delay_ns = delay_q;

   // Two's complement half hours; minus twelve folds to plus twelve
   always_comb begin
      for (int o = 0; o < NUM_OUT; o++) begin
         out_cfg[o].output_tc_format = fmt_q[o];
         out_cfg[o].user_bit_format  = ub_q[o];
         out_cfg[o].color_frame_sync = cfs_q[o];
         out_cfg[o].aux_insert = aen_q[o]
            && (ub_q[o] == TCAUX_UB_EXTENDED);
         if (sign_q[o] && mag_q[o] != `TCAUX_AUX_MAG_MAX) begin
            out_cfg[o].aux_offset_signed = 6'(-{1'b0, mag_q[o]});
         end else begin
            out_cfg[o].aux_offset_signed = {1'b0, mag_q[o]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_q <= `TCAUX_RST_ZERO;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `TCAUX_SEL_OFF) begin
            prdata_q <= {30'h0, sel_q};
         end else if (paddr == `TCAUX_FMT_OFF) begin
            prdata_q <= {26'h0, ub_q[sel_q], 1'b0, cur_std};
         end else if (paddr == `TCAUX_AUX_OFF) begin
            prdata_q <= {24'h0, cfs_q[sel_q], aen_q[sel_q], sign_q[sel_q], mag_q[sel_q]};
         end else if (paddr == `TCAUX_CLK_OFF && sel_ltc) begin
            prdata_q <= {15'h0, ph_q[li][cur_std].clock_ns};
         end else if (paddr == `TCAUX_LINE_OFF && sel_ltc) begin
            prdata_q <= {22'h0, ph_q[li][cur_std].lines};
         end else if (paddr == `TCAUX_FRAME_OFF && sel_ltc) begin
            prdata_q <= {27'h0, ph_q[li][cur_std].frames};
         end else if (paddr == `TCAUX_STAT_OFF) begin
            prdata_q <= delay_q[sel_q*32 +: 32];
         end else begin
            prdata_q <= `TCAUX_RST_ZERO;
         end
      end
   end
   assign prdata = rd_en ? prdata_q : 32'h0000_0000;

   assign pslverr = psel && penable && !(paddr == `TCAUX_SEL_OFF || paddr == `TCAUX_FMT_OFF
      || paddr == `TCAUX_AUX_OFF || paddr == `TCAUX_CLK_OFF || paddr == `TCAUX_LINE_OFF
      || paddr == `TCAUX_FRAME_OFF || (paddr == `TCAUX_STAT_OFF && !pwrite));

endmodule : tcaux_ctrl
`default_nettype wire

/* tcaux_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module tcaux_decoder
   import tcaux_pkg::*;
(
   input  wire tcaux_cfg_type cfg,
   output logic [6:0]         aux_hh
);
   // Offset is taken from the payload only, never from the time value
   always_comb begin
      if (cfg.aux_insert && cfg.user_bit_format == TCAUX_UB_EXTENDED) begin
         aux_hh = {cfg.aux_offset_signed[5], cfg.aux_offset_signed};
      end else begin
         aux_hh = 7'h00;
      end
   end
endmodule : tcaux_decoder
`default_nettype wire

/* tcaux_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module tcaux_ctrl_chk
   import tcaux_pkg::*;
#(
   parameter int NUM_OUT = 4
) (
   input wire logic                   core_clk,
   input wire logic                   rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [NUM_OUT-1:0]     cf_align_ns_valid,
   input wire logic [NUM_OUT*17-1:0]  cf_align_ns,
   input wire tcaux_cfg_type [NUM_OUT-1:0] out_cfg,
   input wire logic [NUM_OUT*32-1:0]  ltc_delay_ns
);
   logic [1:0] sel_q;
   logic [4:0] mag_w;
   assign mag_w = pwdata[4:0];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_q <= 2'h0;
      end else if (psel && penable && pwrite && pready && paddr == 12'h000) begin
         sel_q <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_aux_wr;
      psel && penable && pwrite && pready && paddr == 12'h008;
   endsequence
   property p_mag;
      s_aux_wr ##0 (!pwdata[5] && mag_w <= 5'h18) |=>
         out_cfg[sel_q].aux_offset_signed == {1'b0, $past(mag_w)};
   endproperty
   a_mag: assert property (p_mag) else $error("plus offset wrong");
   property p_minus12;
      s_aux_wr ##0 (pwdata[5:0] == 6'h38) |=> out_cfg[sel_q].aux_offset_signed == 6'h18;
   endproperty
   a_minus12: assert property (p_minus12) else $error("minus twelve wrong");
   property p_en_off;
      s_aux_wr ##0 !pwdata[6] |=> !out_cfg[sel_q].aux_insert;
   endproperty
   a_en_off: assert property (p_en_off) else $error("insert while disabled");
   property p_insert;
      out_cfg[0].aux_insert |-> out_cfg[0].user_bit_format == TCAUX_UB_EXTENDED;
   endproperty
   a_insert: assert property (p_insert) else $error("insert without ext bits");
   property p_range;
      !(out_cfg[0].aux_offset_signed inside {[6'h19:6'h28]});
   endproperty
   a_range: assert property (p_range) else $error("offset out of range");
   property p_vitc;
      !cf_align_ns_valid[2] |=> ltc_delay_ns[95:64] == 32'h0;
   endproperty
   a_vitc: assert property (p_vitc) else $error("vitc delay nonzero");
   property p_fmt;
      out_cfg[0].output_tc_format <= TCAUX_STD_24FPS_NONDROP;
   endproperty
   a_fmt: assert property (p_fmt) else $error("illegal format");
   property p_ro_err;
      psel && penable && (paddr == 12'h018 && pwrite || paddr > 12'h018) |-> pslverr;
   endproperty
   a_ro_err: assert property (p_ro_err) else $error("error not flagged");
   property p_rd_idle;
      !(psel && penable && !pwrite) |-> prdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule : tcaux_ctrl_chk
bind tcaux_ctrl tcaux_ctrl_chk #(.NUM_OUT(NUM_OUT)) i_chk (.core_clk(core_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cf_align_ns_valid(cf_align_ns_valid),
   .cf_align_ns(cf_align_ns), .out_cfg(out_cfg), .ltc_delay_ns(ltc_delay_ns));
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tcaux_defines.svh"
module tb
   import tcaux_pkg::*;
;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, errv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] cf_align_ns_valid;
   logic [67:0] cf_align_ns;
   tcaux_cfg_type [3:0] out_cfg;
   logic [127:0] ltc_delay_ns;
   logic [6:0] dec_hh;
   logic [6:0] dec_ex;
   logic [5:0] aux_sig;
   logic [31:0] dly_ex;
   int fails, checks_done;
   logic [6:0] aux_in [7] = '{7'h43, 7'h63, 7'h78, 7'h77, 7'h59, 7'h40, 7'h23};
   logic [6:0] aux_ex [7] = '{7'h43, 7'h7d, 7'h58, 7'h69, 7'h58, 7'h40, 7'h00};
   tcaux_ctrl i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cf_align_ns_valid(cf_align_ns_valid), .cf_align_ns(cf_align_ns),
      .out_cfg(out_cfg), .ltc_delay_ns(ltc_delay_ns));
   tcaux_decoder i_dec (.cfg(out_cfg[0]), .aux_hh(dec_hh));
   assign aux_sig = out_cfg[0].aux_offset_signed;
   task close_out;
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Holds the request until pready is seen high at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         close_out;
      end
      @(posedge core_clk);
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rdv);
   endtask : rd
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      cf_align_ns_valid = 4'h0;
      cf_align_ns = 68'h0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 7; i++) rd(12'(i * 4), 32'h0, "reset value");
      apb(1'b1, 12'h018, 32'h1);
      chk("status write err", 32'h1, 32'(errv));
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped err", 32'h1, 32'(errv));
      apb(1'b1, 12'h004, 32'h10);
      chk("ub format", 32'(TCAUX_UB_EXTENDED), 32'(out_cfg[0].user_bit_format));
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 12'h008, 32'(aux_in[i]));
         chk("aux insert", 32'(aux_ex[i][6]), 32'(out_cfg[0].aux_insert));
         if (aux_ex[i][6]) begin
            chk("aux value", 32'(aux_ex[i][5:0]), 32'(aux_sig));
         end
         dec_ex = aux_ex[i][6] ? {aux_ex[i][5], aux_ex[i][5:0]} : 7'h00;
         chk("decoded", 32'(dec_ex), 32'(dec_hh));
      end
      apb(1'b1, 12'h008, 32'h43);
      apb(1'b1, 12'h004, 32'h0);
      chk("plain ub insert", 32'h0, 32'(out_cfg[0].aux_insert));
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, 12'h004, 32'(f));
         chk("format", 32'(f), 32'(out_cfg[0].output_tc_format));
         apb(1'b1, 12'h00c, 32'h1ffff);
         apb(1'b1, 12'h010, 32'hffff_ffff);
         apb(1'b1, 12'h014, 32'hffff_ffff);
      end
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, 12'h004, 32'(f));
         rd(12'h00c, (f == 2) ? 32'hf9db : 32'hf81f, "clock max");
         rd(12'h010, (f == 2) ? 32'h270 : 32'h20c, "line max");
         rd(12'h014, (f == 2) ? 32'h18 : 32'h1d, "frame max");
      end
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b1, 12'h00c, 32'h64);
      rd(12'h00c, 32'h0, "24fps phasing");
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h00c, 32'h64);
      rd(12'h00c, 32'h0, "vitc phasing");
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      rd(12'h00c, 32'h0, "other output");
      cf_align_ns <= 68'h1f4 << 17;
      cf_align_ns_valid <= 4'h2;
      apb(1'b1, 12'h004, 32'h2);
      apb(1'b1, 12'h00c, 32'h3e8);
      apb(1'b1, 12'h008, 32'h80);
      chk("cf sync flag", 32'h1, 32'(out_cfg[1].color_frame_sync));
      @(posedge core_clk);
      chk("delay with cf", 32'h5dc, ltc_delay_ns[63:32]);
      chk("24fps delay", 32'h0, ltc_delay_ns[31:0]);
      rd(12'h018, 32'h5dc, "status delay");
      apb(1'b1, 12'h008, 32'h0);
      @(posedge core_clk);
      chk("delay no cf", 32'h3e8, ltc_delay_ns[63:32]);
      apb(1'b1, 12'h010, 32'h2);
      apb(1'b1, 12'h014, 32'h1);
      dly_ex = 32'h3e8 + 32'h2 * `TCAUX_LINE_NS_25 + `TCAUX_FRAME_NS_25;
      @(posedge core_clk);
      chk("delay sum", dly_ex, ltc_delay_ns[63:32]);
      apb(1'b1, 12'h004, 32'h17);
      rd(12'h004, 32'h12, "bad format kept");
      close_out;
   end
endmodule : tb
`default_nettype wire
